// >>> hdl/system_mode_status_regs.sv
`default_nettype none

// Operation
// RQ1: receive_pin_select low routes pin A, high routes pin B to the serial receive input.
// RQ2: receive_pin_select resets to zero so pin A is the default source.
// RQ3: uart_mode_select high also feeds pin A to the receive frame-sync input.
// RQ4: uart_mode_select high drives the frame-sync/ROM pin from the core flag.
// RQ5: uart_mode_select low leaves plain serial-port wiring and resets to zero.
// RQ6: bit 6 picks single (0) or double (1) PWM update and resets to zero.
// RQ7: bit 8 picks offset (0) or independent (1) aux PWM mode and resets to zero.
// RQ8: status bit 0 follows the PWM shutdown pin level.
// RQ9: status bit 2 follows the PWM polarity pin level.
// RQ10: status bit 1 is set by a watchdog timeout and survives the reset it causes.
// RQ11: status bit 3 reads zero while the PWM timer counts down, one while it counts up.
// RQ12: unused bits read zero and writes to status or unused bits do nothing.
module system_mode_status_regs
  import sysctl_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          serialRxPinA,
  input  wire logic          serialRxPinB,
  input  wire logic          rxFrameSyncPin,
  input  wire logic          coreFlagOut,
  input  wire logic          pwmShutdownPin,
  input  wire logic          pwmPolarityPin,
  input  wire logic          pwmTimerCountsUp,
  input  wire logic          watchdogTimeout,
  input  wire logic          powerOnReset,
  output serial_route_t      serialRoute,
  output pwm_mode_t          pwmMode,
  output logic               irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [8:0] modeControl;
  logic       watchdogFlag;
  logic [3:0] statusLive;
  logic [3:0] statusPrev;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic        access   = psel && penable;
  wire logic        wrAccess = access && pwrite;
  wire logic        setupRead = psel && !penable && !pwrite;
  wire logic        hitMode  = paddr[17:0] == MODE_CONTROL_ADDR && paddr[31:18] == 14'h0000;
  wire logic        hitStat  = paddr[17:0] == SYSTEM_STATUS_ADDR && paddr[31:18] == 14'h0000;
  wire logic        hitIrqS  = paddr[17:0] == IRQ_STATUS_ADDR && paddr[31:18] == 14'h0000;
  wire logic        hitIrqM  = paddr[17:0] == IRQ_MASK_ADDR && paddr[31:18] == 14'h0000;
  wire logic        hitAny   = hitMode || hitStat || hitIrqS || hitIrqM;
  wire logic [3:0]  statusWord = {statusLive[PHASE_BIT], statusLive[POL_BIT],
                                  watchdogFlag, statusLive[TRIP_BIT]};
  wire logic [3:0]  statusEdge = statusWord ^ statusPrev;
  wire logic [3:0]  w1c = (wrAccess && hitIrqS) ? pwdata[3:0] : 4'h0;
  logic [31:0]      readMux;

  // unused bits read zero; status is read-only, so writes to it vanish
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitMode) begin
      readMux = {23'h000000, modeControl}; // RQ12
    end else if (hitStat) begin
      readMux = {28'h0000000, statusWord}; // RQ8 RQ9 RQ10 RQ11 RQ12
    end else if (hitIrqS) begin
      readMux = {28'h0000000, irqStatus};
    end else if (hitIrqM) begin
      readMux = {28'h0000000, irqMask};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access && !hitAny;

  // loaded in setup phase: data already stands at the zero-wait access edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setupRead) begin
      prdata <= readMux;
    end
  end

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      modeControl <= MODE_CONTROL_RESET; // RQ2 RQ5 RQ6 RQ7
    end else if (wrAccess && hitMode) begin
      modeControl <= pwdata[8:0] & MODE_CONTROL_MASK; // RQ12
    end
  end

  // ----------------------------------------
  // status sampling
  // ----------------------------------------
  // pins arrive synchronous, so status shows their present level
  assign statusLive = {pwmTimerCountsUp, pwmPolarityPin, 1'b0, pwmShutdownPin}; // RQ8 RQ9 RQ11

  // watchdog flag is not touched by rstn: the timeout itself causes that reset,
  // so only a power-on reset clears it
  always_ff @(posedge clk_sys) begin
    if (watchdogTimeout) begin
      watchdogFlag <= 1'b1; // RQ10
    end else if (powerOnReset) begin
      watchdogFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupts: any status bit change is an event
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      statusPrev <= statusWord;
      irqStatus  <= IRQ_RESET;
      irqMask    <= IRQ_RESET;
    end else begin
      statusPrev <= statusWord;
      irqStatus  <= (irqStatus & ~w1c) | statusEdge;
      if (wrAccess && hitIrqM) begin
        irqMask <= pwdata[3:0];
      end
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ----------------------------------------
  // serial port one routing and pwm modes
  // ----------------------------------------
  wire logic uartMode = modeControl[UART_BIT];

  assign serialRoute.serialRx    = modeControl[RX_SEL_BIT] ? serialRxPinB
                                                           : serialRxPinA; // RQ1
  assign serialRoute.rxFrameSync = uartMode ? serialRxPinA : rxFrameSyncPin; // RQ3 RQ5
  assign serialRoute.romResetOut = uartMode ? coreFlagOut : 1'b0; // RQ4
  assign serialRoute.romResetOe  = uartMode; // RQ4 RQ5
  assign pwmMode.pwmDoubleUpdate = modeControl[PWM_DOUBLE_BIT]; // RQ6
  assign pwmMode.auxIndependent  = modeControl[AUX_INDEP_BIT]; // RQ7

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_rx_select;
    @(posedge clk_sys) disable iff (!rstn)
      serialRoute.serialRx == (modeControl[RX_SEL_BIT] ? serialRxPinB : serialRxPinA);
  endproperty
  a_rx_select: assert property (p_rx_select) else $error("receive source wrong"); // RQ1

  property p_reset_mode;
    @(posedge clk_sys) !rstn |=> modeControl == 9'h000;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not cleared"); // RQ2

  property p_uart_fs;
    @(posedge clk_sys) disable iff (!rstn)
      uartMode |-> serialRoute.rxFrameSync == serialRxPinA;
  endproperty
  a_uart_fs: assert property (p_uart_fs) else $error("frame sync not from pin A"); // RQ3

  property p_rom_reset;
    @(posedge clk_sys) disable iff (!rstn)
      uartMode |-> serialRoute.romResetOe && serialRoute.romResetOut == coreFlagOut;
  endproperty
  a_rom_reset: assert property (p_rom_reset) else $error("rom reset not driven"); // RQ4

  property p_sport_mode;
    @(posedge clk_sys) disable iff (!rstn)
      !uartMode |-> !serialRoute.romResetOe && serialRoute.rxFrameSync == rxFrameSyncPin;
  endproperty
  a_sport_mode: assert property (p_sport_mode) else $error("extra routing in port mode"); // RQ5

  property p_pwm_write;
    @(posedge clk_sys) disable iff (!rstn)
      wrAccess && hitMode |=> pwmMode.pwmDoubleUpdate == $past(pwdata[6])
        && pwmMode.auxIndependent == $past(pwdata[8]);
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("pwm mode not written"); // RQ6

  property p_trip_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitStat |=> prdata[TRIP_BIT] == $past(pwmShutdownPin)
        && prdata[31:4] == 28'h0000000;
  endproperty
  a_trip_read: assert property (p_trip_read) else $error("status read wrong"); // RQ8

  property p_wdog_sticky;
    @(posedge clk_sys)
      watchdogTimeout |=> watchdogFlag;
  endproperty
  a_wdog_sticky: assert property (p_wdog_sticky) else $error("watchdog flag not set"); // RQ10

  property p_wdog_keep;
    @(posedge clk_sys)
      watchdogFlag && !powerOnReset |=> watchdogFlag;
  endproperty
  a_wdog_keep: assert property (p_wdog_keep) else $error("watchdog flag lost"); // RQ10

  property p_wdog_clear;
    @(posedge clk_sys)
      powerOnReset && !watchdogTimeout |=> !watchdogFlag;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog flag kept"); // RQ10

  property p_wdog_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitStat |=> prdata[WDOG_BIT] == $past(watchdogFlag);
  endproperty
  a_wdog_read: assert property (p_wdog_read) else $error("watchdog bit read wrong"); // RQ10

  property p_pol_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitStat |=> prdata[POL_BIT] == $past(pwmPolarityPin);
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity bit read wrong"); // RQ9

  property p_phase_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitStat |=> prdata[PHASE_BIT] == $past(pwmTimerCountsUp);
  endproperty
  a_phase_read: assert property (p_phase_read) else $error("phase bit read wrong"); // RQ11

  property p_rx_default;
    @(posedge clk_sys)
      !rstn |=> serialRoute.serialRx == serialRxPinA;
  endproperty
  a_rx_default: assert property (p_rx_default) else $error("pin A not default"); // RQ2

  property p_uart_reset;
    @(posedge clk_sys)
      !rstn |=> !serialRoute.romResetOe && serialRoute.rxFrameSync == rxFrameSyncPin;
  endproperty
  a_uart_reset: assert property (p_uart_reset) else $error("port mode not default"); // RQ5

  property p_pwm_reset;
    @(posedge clk_sys)
      !rstn |=> !pwmMode.pwmDoubleUpdate;
  endproperty
  a_pwm_reset: assert property (p_pwm_reset) else $error("double update after reset"); // RQ6

  property p_aux_reset;
    @(posedge clk_sys)
      !rstn |=> !pwmMode.auxIndependent;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux mode after reset"); // RQ7

  property p_rom_low;
    @(posedge clk_sys) disable iff (!rstn)
      !uartMode |-> !serialRoute.romResetOut;
  endproperty
  a_rom_low: assert property (p_rom_low) else $error("rom reset driven in port mode"); // RQ5

  property p_mode_write;
    @(posedge clk_sys) disable iff (!rstn)
      wrAccess && hitMode |=> modeControl[RX_SEL_BIT] == $past(pwdata[RX_SEL_BIT])
        && uartMode == $past(pwdata[UART_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("routing bits not written"); // RQ1 RQ3

  property p_mode_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitMode |=> prdata == {23'h000000, $past(modeControl)};
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong"); // RQ1

  property p_mode_unused;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && hitMode |=> (prdata & ~{23'h000000, MODE_CONTROL_MASK}) == 32'h0000_0000;
  endproperty
  a_mode_unused: assert property (p_mode_unused) else $error("unused mode bit set"); // RQ12

  property p_mode_kept;
    @(posedge clk_sys) disable iff (!rstn)
      !(wrAccess && hitMode) |=> $stable(modeControl);
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("mode changed by other write"); // RQ12

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (!rstn)
      setupRead && !hitAny |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero"); // RQ12

  property p_trip_event;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(pwmShutdownPin) |=> irqStatus[TRIP_BIT];
  endproperty
  a_trip_event: assert property (p_trip_event) else $error("trip change not flagged"); // RQ8

  property p_trip_w1c;
    @(posedge clk_sys) disable iff (!rstn)
      wrAccess && hitIrqS && pwdata[TRIP_BIT] && !statusEdge[TRIP_BIT] |=> !irqStatus[TRIP_BIT];
  endproperty
  a_trip_w1c: assert property (p_trip_w1c) else $error("trip flag not cleared"); // RQ8

endmodule
`default_nettype wire

// >>> common/sysctl_pkg.sv
`default_nettype none
package sysctl_pkg;

  // ----------------------------------------
  // register map (printed offsets are word indices)
  // ----------------------------------------
  localparam logic [15:0] MODE_CONTROL_IDX  = 16'h2015;
  localparam logic [15:0] SYSTEM_STATUS_IDX = 16'h2016;
  localparam logic [15:0] IRQ_STATUS_IDX    = 16'h2017;
  localparam logic [15:0] IRQ_MASK_IDX      = 16'h2018;
  localparam logic [17:0] MODE_CONTROL_ADDR  = {MODE_CONTROL_IDX, 2'b00};
  localparam logic [17:0] SYSTEM_STATUS_ADDR = {SYSTEM_STATUS_IDX, 2'b00};
  localparam logic [17:0] IRQ_STATUS_ADDR    = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [17:0] IRQ_MASK_ADDR      = {IRQ_MASK_IDX, 2'b00};

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int RX_SEL_BIT     = 4;
  localparam int UART_BIT       = 5;
  localparam int PWM_DOUBLE_BIT = 6;
  localparam int AUX_INDEP_BIT  = 8;
  localparam int TRIP_BIT       = 0;
  localparam int WDOG_BIT       = 1;
  localparam int POL_BIT        = 2;
  localparam int PHASE_BIT      = 3;
  localparam logic [8:0] MODE_CONTROL_RESET = 9'h000;
  localparam logic [8:0] MODE_CONTROL_MASK  = 9'h170;
  localparam logic [3:0] IRQ_RESET          = 4'h0;

  typedef struct packed {
    logic serialRx;
    logic rxFrameSync;
    logic romResetOut;
    logic romResetOe;
  } serial_route_t;

  typedef struct packed {
    logic pwmDoubleUpdate;
    logic auxIndependent;
  } pwm_mode_t;

endpackage
`default_nettype wire

// >>> verif/pwm_timer_model.sv
`default_nettype none
module pwm_timer_model #(
  parameter int HALF = 6
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      countsUp
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial countsUp = 1'b0;
  // stopping the timer keeps the phase steady while software reads it
  always @(posedge clk_sys) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) countsUp <= ~countsUp;
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_system_mode_status_regs.sv
`default_nettype none
module test_system_mode_status_regs
  import sysctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, run = 1;
  logic [31:0]   paddr = '0, pwdata = '0, rd, prdata;
  logic          pready, pslverr, irq, countsUp, ers;
  logic          pinA = 0, pinB = 0, fsPin = 0, flag = 0, trip = 0, pol = 0, wdt = 0, por = 1;
  serial_route_t route;
  pwm_mode_t     mode;
  int            err_count = 0, tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  system_mode_status_regs i_system_mode_status_regs (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serialRxPinA(pinA),
    .serialRxPinB(pinB), .rxFrameSyncPin(fsPin), .coreFlagOut(flag), .pwmShutdownPin(trip),
    .pwmPolarityPin(pol), .pwmTimerCountsUp(countsUp), .watchdogTimeout(wdt),
    .powerOnReset(por), .serialRoute(route), .pwmMode(mode), .irq(irq));
  pwm_timer_model i_pwm_timer_model (.clk_sys(clk_sys), .run(run), .countsUp(countsUp));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read data stands from the setup edge on, so it is taken at the access edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    ers = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      results();
    end
    @(posedge clk_sys);
  endtask
  task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  initial begin
    logic [31:0] d;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    por <= 1'b0;
    @(posedge clk_sys);
    rdchk("mode reset", MODE_CONTROL_ADDR, 32'h0);
    chk("oe reset", route.romResetOe, 0);
    apb(1'b1, MODE_CONTROL_ADDR, 32'hFFFFFFFF);
    rdchk("mode unused", MODE_CONTROL_ADDR, 32'h170);
    for (int i = 0; i < 16; i++) begin
      pinA <= ~i[0] ^ i[3];
      pinB <= i[0] ^ i[3];
      fsPin <= i[0] ^ i[3];
      flag <= i[2];
      d = {23'h0, i[3], 1'b0, i[2], i[1], i[0], 4'h0};
      apb(1'b1, MODE_CONTROL_ADDR, d);
      chk("rx", route.serialRx, !i[3]);
      chk("fsync", route.rxFrameSync, i[1] ^ i[0] ^ i[3]);
      chk("rom oe", route.romResetOe, i[1]);
      if (i[1]) chk("rom out", route.romResetOut, i[2]);
      chk("pwm mode", mode, {i[2], i[3]});
      rdchk("mode rd", MODE_CONTROL_ADDR, d);
    end
    for (int i = 0; i < 4; i++) begin
      repeat (6) @(posedge clk_sys);
      run <= 1'b0;
      trip <= i[0];
      pol <= i[1];
      @(posedge clk_sys);
      rdchk("status", SYSTEM_STATUS_ADDR, {countsUp, i[1], 1'b0, i[0]});
      run <= 1'b1;
    end
    run <= 1'b0;
    trip <= 1'b0;
    apb(1'b1, SYSTEM_STATUS_ADDR, 32'hF);
    rdchk("status ro", SYSTEM_STATUS_ADDR, {countsUp, 3'b100});
    wdt <= 1'b1;
    @(posedge clk_sys);
    wdt <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdchk("wdog kept", SYSTEM_STATUS_ADDR, {countsUp, 3'b110});
    por <= 1'b1;
    @(posedge clk_sys);
    por <= 1'b0;
    rdchk("por clears", SYSTEM_STATUS_ADDR, {countsUp, 3'b100});
    rdchk("unmapped", 32'h8064, 32'h0);
    chk("slverr", ers, 1);
    apb(1'b1, IRQ_STATUS_ADDR, 32'hF);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    chk("irq idle", irq, 0);
    trip <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("irq set", irq, 1);
    rdchk("irq status", IRQ_STATUS_ADDR, 32'h1);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    chk("irq masked", irq, 0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
    chk("irq cleared", irq, 0);
    results();
  end
endmodule
`default_nettype wire
